/* pxb_cfg.svh */
/*
 Constants of the port crossbar: register addresses, reset values,
 write masks, field positions and signal order numbers.
 Assumes an 8-bit register bus with 8-bit addresses.
*/
`ifndef PXB_CFG_SVH
`define PXB_CFG_SVH
// ==========================================================
// Register addresses and reset values
`define PXB_ADDR_P0     8'h80
`define PXB_ADDR_P1     8'h90
`define PXB_ADDR_P0DRV  8'ha4
`define PXB_ADDR_RA     8'he1
`define PXB_ADDR_RB     8'he2
`define PXB_ADDR_RC     8'he3
`define PXB_ADDR_RD     8'he4
`define PXB_RST_LATCH   8'hff
`define PXB_RST_CFG     8'h00
`define PXB_WMASK_ALL   8'hff
`define PXB_WMASK_C     8'hdf
`define PXB_WMASK_D     8'h8f
// ==========================================================
// Field positions
`define PXB_A_CMP_A     7
`define PXB_A_ECI       6
`define PXB_A_CEX_HI    5
`define PXB_A_CEX_LO    3
`define PXB_A_UART0     2
`define PXB_A_SPI       1
`define PXB_A_SMB       0
`define PXB_C_PU_OFF    7
`define PXB_C_ROUTER_ON 6
`define PXB_C_UART1     2
`define PXB_C_MEMLO     1
`define PXB_C_ADC_A     0
`define PXB_D_CAN_DRV   7
// ==========================================================
// Signal order numbers and sizes
`define PXB_NSIG        33
`define PXB_NPIN        32
`define PXB_CEX_MAX     3'h6
`define PXB_SIG_RX0     6'h01
`define PXB_SIG_SDA     6'h06
`define PXB_SIG_SCL     6'h07
`define PXB_SIG_RX1     6'h09
`define PXB_SIG_ARRAY_MODULE_PIN_FIRST    10
`endif

/* pxb_pkg.sv */
/*
 Types shared by the port crossbar files.
 Assumes the constants header for the signal vector widths.
*/
`include "pxb_cfg.svh"
package pxb_pkg;
    // Register bus request from the core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       rmw;
    } pxb_sfr_req_t;
    // Levels and drive enables that peripherals offer to pins
    typedef struct packed {
        logic [`PXB_NSIG-1:0] drv;
        logic [`PXB_NSIG-1:0] drv_en;
    } pxb_periph_t;
    // External memory interface view
    typedef struct packed {
        logic       nonmux;
        logic       busy;
        logic [2:0] strobe;
        logic [7:0] addr_hi;
    } pxb_memif_t;
endpackage

/* pxb_reg.sv */
/*
 One 8-bit configuration register at a fixed bus address.
 Assumes writes are one-cycle strobes on the system clock.
*/
`timescale 1ns/100ps
module pxb_reg #(
    parameter logic [7:0] ADDR  = 8'h00,
    parameter logic [7:0] RST   = 8'h00,
    parameter logic [7:0] WMASK = 8'hff
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       wr,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q
);
    logic [7:0] q_reg;
    logic [7:0] q_next;
    // Masked bits keep their reset value for ever
    assign q_next = (wr && addr == ADDR) ? ((q_reg & ~WMASK) | (wdata & WMASK)) : q_reg;
    assign q      = q_reg;
    // State
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) q_reg <= RST;
        else        q_reg <= q_next;
    end
endmodule

/* pxb_pin.sv */
/*
 Output stage of one port pin: drive, open-drain release, pullup.
 Assumes value and drive settle within one system clock.
*/
`timescale 1ns/100ps
module pxb_pin (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic value,
    input  wire logic drive,
    input  wire logic push_pull,
    input  wire logic router_on,
    input  wire logic pull_req,
    output logic      out,
    output logic      oe,
    output logic      pu
);
    logic out_reg, oe_reg, pu_reg;
    logic out_next, oe_next;
    // Open-drain only pulls low; a high level releases the pin
    assign oe_next  = router_on & drive & (push_pull | ~value);
    assign out_next = push_pull & value;
    assign out = out_reg;
    assign oe  = oe_reg;
    assign pu  = pu_reg;
    // Registered so that pins change cleanly on one edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= 1'b0;
            oe_reg  <= 1'b0;
            pu_reg  <= 1'b1;
        end else begin
            out_reg <= out_next;
            oe_reg  <= oe_next;
            pu_reg  <= pull_req;
        end
    end
endmodule

/* pxb_top.sv */
/*
 Port crossbar: priority assignment of peripheral signals to the
 32 pins of ports 0 to 3, port 0/1 latches, port 0 drive select.
 Assumes pin inputs are synchronous to clock and the core bus
 gives one-cycle write and read strobes. Port 1 modes and port 2/3
 drive modes arrive as plain inputs from registers kept elsewhere.
*/
`timescale 1ns/100ps
`include "pxb_cfg.svh"
module pxb_top (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire pxb_pkg::pxb_sfr_req_t   sfr,
    output logic      [7:0]              sfr_rdata,
    output logic                         sfr_hit,
    input  wire logic [`PXB_NPIN-1:0]    pin_in,
    output logic      [`PXB_NPIN-1:0]    pin_out,
    output logic      [`PXB_NPIN-1:0]    pin_oe,
    output logic      [`PXB_NPIN-1:0]    pin_pullup,
    input  wire pxb_pkg::pxb_periph_t    periph,
    output logic      [`PXB_NSIG-1:0]    periph_in,
    input  wire pxb_pkg::pxb_memif_t     memif,
    input  wire logic [1:0]              uart_mode0,
    input  wire logic                    spi_three_wire,
    input  wire logic [7:0]              port1_analog_select,
    input  wire logic [7:0]              port1_drive_select,
    input  wire logic [15:0]             port23_drive_select,
    output logic                         can_tx_drive_sel
);
    // ==========================================================
    // Registers
    logic [7:0] port0_latch, port1_latch, port0_drive_select;
    logic [7:0] route_enable_a, route_enable_b, route_enable_c, route_enable_d;

    // Latches reset high so that open-drain pins start released
    pxb_reg #(.ADDR(`PXB_ADDR_P0), .RST(`PXB_RST_LATCH), .WMASK(`PXB_WMASK_ALL)) u_p0 (
        .clock(clock), .rst_n(rst_n), .wr(sfr.wr), .addr(sfr.addr), .wdata(sfr.wdata), .q(port0_latch));
    pxb_reg #(.ADDR(`PXB_ADDR_P1), .RST(`PXB_RST_LATCH), .WMASK(`PXB_WMASK_ALL)) u_p1 (
        .clock(clock), .rst_n(rst_n), .wr(sfr.wr), .addr(sfr.addr), .wdata(sfr.wdata), .q(port1_latch));
    pxb_reg #(.ADDR(`PXB_ADDR_P0DRV), .RST(`PXB_RST_CFG), .WMASK(`PXB_WMASK_ALL)) u_p0d (
        .clock(clock), .rst_n(rst_n), .wr(sfr.wr), .addr(sfr.addr), .wdata(sfr.wdata),
        .q(port0_drive_select));
    pxb_reg #(.ADDR(`PXB_ADDR_RA), .RST(`PXB_RST_CFG), .WMASK(`PXB_WMASK_ALL)) u_ra (
        .clock(clock), .rst_n(rst_n), .wr(sfr.wr), .addr(sfr.addr), .wdata(sfr.wdata), .q(route_enable_a));
    pxb_reg #(.ADDR(`PXB_ADDR_RB), .RST(`PXB_RST_CFG), .WMASK(`PXB_WMASK_ALL)) u_rb (
        .clock(clock), .rst_n(rst_n), .wr(sfr.wr), .addr(sfr.addr), .wdata(sfr.wdata), .q(route_enable_b));
    // Unused and reserved bits are masked so they always read zero
    pxb_reg #(.ADDR(`PXB_ADDR_RC), .RST(`PXB_RST_CFG), .WMASK(`PXB_WMASK_C)) u_rc (
        .clock(clock), .rst_n(rst_n), .wr(sfr.wr), .addr(sfr.addr), .wdata(sfr.wdata), .q(route_enable_c));
    pxb_reg #(.ADDR(`PXB_ADDR_RD), .RST(`PXB_RST_CFG), .WMASK(`PXB_WMASK_D)) u_rd (
        .clock(clock), .rst_n(rst_n), .wr(sfr.wr), .addr(sfr.addr), .wdata(sfr.wdata), .q(route_enable_d));

    // ==========================================================
    // Control fields
    wire       router_on        = route_enable_c[`PXB_C_ROUTER_ON];
    wire       pullup_global_off = route_enable_c[`PXB_C_PU_OFF];
    wire       memif_low_port_en = route_enable_c[`PXB_C_MEMLO];
    wire [2:0] array_module_io_count = route_enable_a[`PXB_A_CEX_HI:`PXB_A_CEX_LO];
    // Address drive needs low-port mode, nonmux mode and a live access
    wire       addr_drive = memif_low_port_en & memif.nonmux & memif.busy;
    assign can_tx_drive_sel = route_enable_d[`PXB_D_CAN_DRV];

    // ==========================================================
    // Request vector in priority order; everything gated by router
    logic [`PXB_NSIG-1:0] req;
    wire u0  = route_enable_a[`PXB_A_UART0];
    wire spi = route_enable_a[`PXB_A_SPI];
    wire smb = route_enable_a[`PXB_A_SMB];
    wire u1  = route_enable_c[`PXB_C_UART1];
    // Serial buses first; SPI sits between the first UART and the SMBus
    assign req[1:0] = {2{router_on & u0}};
    assign req[4:2] = {3{router_on & spi}};
    assign req[5]   = router_on & spi & ~spi_three_wire;
    assign req[7:6] = {2{router_on & smb}};
    assign req[9:8] = {2{router_on & u1}};
    // A count, not a mask: field values above six still route six
    for (genvar c = 0; c < 6; c++) begin : g_cex
        assign req[`PXB_SIG_ARRAY_MODULE_PIN_FIRST+c] = router_on && (array_module_io_count > 3'(c));
    end
    // Counter input and comparators follow the module pins
    assign req[16] = router_on & route_enable_a[`PXB_A_ECI];
    assign req[17] = router_on & route_enable_a[`PXB_A_CMP_A];
    assign req[18] = router_on & route_enable_b[0];
    assign req[19] = router_on & route_enable_d[3];
    // Timer inputs, interrupts, clock out, in fixed order
    assign req[25:20] = {6{router_on}} & {route_enable_b[6], route_enable_b[5], route_enable_b[4],
                                          route_enable_b[3], route_enable_b[2], route_enable_b[1]};
    assign req[27:26] = {2{router_on}} & {route_enable_d[1], route_enable_d[0]};
    assign req[29:28] = {2{router_on}} & {route_enable_c[4], route_enable_c[3]};
    assign req[30] = router_on & route_enable_b[7];
    assign req[31] = router_on & route_enable_c[`PXB_C_ADC_A];
    assign req[32] = router_on & route_enable_d[2];

    // ==========================================================
    // Skipped pins: memory strobes on port 0, analog pins on port 1
    logic [`PXB_NPIN-1:0] skip;
    assign skip[4:0]   = 5'h00;
    // Nonmux mode has no address latch pulse, so pin 5 stays free
    assign skip[5]     = memif_low_port_en & ~memif.nonmux;
    assign skip[7:6]   = {2{memif_low_port_en}};
    assign skip[15:8]  = ~port1_analog_select;
    assign skip[31:16] = 16'h0000;

    // ==========================================================
    // Ranks: the k-th requested signal takes the k-th pin that is not skipped
    // Prefix sums cost adders but avoid a ripple search per pin
    logic [5:0] sig_rank [0:`PXB_NSIG];
    logic [5:0] pin_rank [0:`PXB_NPIN];
    assign sig_rank[0] = 6'h00;
    assign pin_rank[0] = 6'h00;
    for (genvar s = 0; s < `PXB_NSIG; s++) begin : g_srank
        assign sig_rank[s+1] = sig_rank[s] + {5'h00, req[s]};
    end
    for (genvar p = 0; p < `PXB_NPIN; p++) begin : g_prank
        assign pin_rank[p+1] = pin_rank[p] + {5'h00, ~skip[p]};
    end

    // Pin-side selection; signals beyond the last pin are dropped
    logic [`PXB_NPIN-1:0] pin_hit;
    logic [5:0]           pin_sel [0:`PXB_NPIN-1];
    always_comb begin
        for (int p = 0; p < `PXB_NPIN; p++) begin
            pin_hit[p] = 1'b0;
            pin_sel[p] = 6'h00;
            for (int s = 0; s < `PXB_NSIG; s++) begin
                if (req[s] && !skip[p] && sig_rank[s] == pin_rank[p]) begin
                    pin_hit[p] = 1'b1;
                    pin_sel[p] = 6'(s);
                end
            end
        end
    end

    // ==========================================================
    // Pin sources and output stages
    wire [31:0] latch32   = {16'hffff, port1_latch, port0_latch};
    wire [31:0] mem32     = {24'hffffff, memif.strobe, 5'h1f};
    wire [31:0] addr32    = {16'hffff, memif.addr_hi, 8'hff};
    wire [31:0] drvsel32  = {port23_drive_select, port1_drive_select, port0_drive_select};
    wire [31:0] dig_mask  = {16'hffff, port1_analog_select, 8'hff};
    wire [31:0] pin_dig   = pin_in & dig_mask;
    logic [31:0] force_od;

    for (genvar p = 0; p < `PXB_NPIN; p++) begin : g_pin
        // Strobes and address override only reach unrouted pins
        wire [5:0] s   = pin_sel[p];
        wire memsk     = skip[p] && (p < 8);
        wire a_ovr     = addr_drive && !skip[p] && (p >= 8) && (p < 16);
        wire od_sig    = (s == `PXB_SIG_SDA) || (s == `PXB_SIG_SCL) ||
                         (s == `PXB_SIG_RX0 && uart_mode0[0]) || (s == `PXB_SIG_RX1 && uart_mode0[1]);
        // Strobes idle high, so AND lets the latch also hold a pin low
        wire val = pin_hit[p] ? periph.drv[s] :
                   memsk      ? (latch32[p] & mem32[p]) :
                   a_ovr      ? addr32[p] : latch32[p];
        // Ports 2 and 3 have no latch here; unrouted they stay released
        wire drv = pin_hit[p] ? periph.drv_en[s] : (p < 16);
        // Forced open-drain overrides the drive select bit
        assign force_od[p] = pin_hit[p] & od_sig;
        pxb_pin u_pin (
            .clock     (clock),
            .rst_n     (rst_n),
            .value     (val),
            .drive     (drv),
            .push_pull (drvsel32[p] & ~force_od[p]),
            .router_on (router_on),
            .pull_req  (~pullup_global_off & dig_mask[p]),
            .out       (pin_out[p]),
            .oe        (pin_oe[p]),
            .pu        (pin_pullup[p])
        );
    end

    // ==========================================================
    // Pin levels back to peripherals; unrouted inputs idle high
    // One register stage keeps pin glitches out of peripheral logic
    logic [`PXB_NSIG-1:0] periph_in_reg, periph_in_next;
    always_comb begin
        periph_in_next = {`PXB_NSIG{1'b1}};
        for (int p = 0; p < `PXB_NPIN; p++) begin
            if (pin_hit[p]) periph_in_next[pin_sel[p]] = pin_dig[p];
        end
    end
    assign periph_in = periph_in_reg;

    // ==========================================================
    // Read path: ports show pin levels, except during read-modify-write
    // Unmapped addresses read zero, so stray reads are harmless
    logic [7:0] rdata_reg, rd_mux;
    wire hit_p0 = sfr.addr == `PXB_ADDR_P0;
    wire hit_p1 = sfr.addr == `PXB_ADDR_P1;
    assign sfr_hit = hit_p0 | hit_p1 | (sfr.addr == `PXB_ADDR_P0DRV) | (sfr.addr == `PXB_ADDR_RA) |
                     (sfr.addr == `PXB_ADDR_RB) | (sfr.addr == `PXB_ADDR_RC) | (sfr.addr == `PXB_ADDR_RD);
    assign rd_mux = hit_p0 ? (sfr.rmw ? port0_latch : pin_dig[7:0]) :
                    hit_p1 ? (sfr.rmw ? port1_latch : pin_dig[15:8]) :
                    (sfr.addr == `PXB_ADDR_P0DRV) ? port0_drive_select :
                    (sfr.addr == `PXB_ADDR_RA) ? route_enable_a :
                    (sfr.addr == `PXB_ADDR_RB) ? route_enable_b :
                    (sfr.addr == `PXB_ADDR_RC) ? route_enable_c :
                    (sfr.addr == `PXB_ADDR_RD) ? route_enable_d : 8'h00;
    assign sfr_rdata = rdata_reg;

    // Read data and peripheral inputs are registered
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg     <= 8'h00;
            periph_in_reg <= {`PXB_NSIG{1'b1}};
        end else begin
            if (sfr.rd) rdata_reg <= rd_mux;
            periph_in_reg <= periph_in_next;
        end
    end

    // ==========================================================
    // Checks
    a_router_off_idle: assert property (@(posedge clock) disable iff (!rst_n)
        (!router_on && !$past(router_on)) |-> (pin_oe == 32'h0 && pin_hit == 32'h0))
        else $error("pins driven while router is off");

    a_uart0_pins: assert property (@(posedge clock) disable iff (!rst_n)
        (router_on && u0) |-> (pin_hit[1:0] == 2'h3 && pin_sel[0] == 6'h00 && pin_sel[1] == 6'h01))
        else $error("first UART not on port 0 pins 0 and 1");

    a_unused_bit_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (sfr.wr && sfr.addr == `PXB_ADDR_RC) |=> (route_enable_c[5] == 1'b0))
        else $error("unused bit 5 became set");

    a_reserved_d_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (sfr.wr && sfr.addr == `PXB_ADDR_RD) |=> (route_enable_d[6:4] == 3'h0))
        else $error("reserved bits became set");

    a_memif_skip_pins: assert property (@(posedge clock) disable iff (!rst_n)
        memif_low_port_en |-> (pin_hit[7:6] == 2'h0 && (memif.nonmux || !pin_hit[5])))
        else $error("memory strobe pin was routed");

    a_open_drain_forced: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 (($past(force_od) & pin_oe & pin_out) == 32'h0))
        else $error("forced open-drain pin driven high");

    a_analog_read_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (sfr.rd && hit_p1 && !sfr.rmw) |=> ((sfr_rdata & ~$past(port1_analog_select)) == 8'h00))
        else $error("analog pin read nonzero");

    a_latch_write: assert property (@(posedge clock) disable iff (!rst_n)
        (sfr.wr && hit_p0) |=> (port0_latch == $past(sfr.wdata)))
        else $error("port 0 latch not updated");

    a_pullup_off: assert property (@(posedge clock) disable iff (!rst_n)
        (pullup_global_off && $past(pullup_global_off)) |-> (pin_pullup == 32'h0))
        else $error("pullup on while globally off");

    a_cex_count: assert property (@(posedge clock) disable iff (!rst_n)
        (router_on && array_module_io_count <= `PXB_CEX_MAX) |->
            ($countones(req[15:10]) == 32'(array_module_io_count)))
        else $error("array module outputs miscounted");

    // Pin counts, skips and drive modes
    a_spi_pin_count: assert property (@(posedge clock) disable iff (!rst_n)
        (router_on && spi) |-> ($countones(req[5:2]) == (spi_three_wire ? 3 : 4)))
        else $error("SPI pin count wrong");

    a_smbus_pin_pair: assert property (@(posedge clock) disable iff (!rst_n)
        (router_on && smb) |-> (req[7:6] == 2'h3))
        else $error("SMBus pins not requested");

    a_uart1_pin_pair: assert property (@(posedge clock) disable iff (!rst_n)
        (router_on && u1) |-> (req[9:8] == 2'h3))
        else $error("second UART pins not requested");

    a_low_port_clear: assert property (@(posedge clock) disable iff (!rst_n)
        !memif_low_port_en |-> (skip[7:5] == 3'h0))
        else $error("port 0 pin skipped without low-port mode");

    a_analog_skip: assert property (@(posedge clock) disable iff (!rst_n)
        ((pin_hit[15:8] & ~port1_analog_select) == 8'h00))
        else $error("analog pin given a signal");

    a_open_drain_mode: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rst_n) |-> ((pin_out & ~$past(drvsel32)) == 32'h0))
        else $error("open-drain pin driven high");

    a_pullup_analog: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rst_n) |-> ((pin_pullup & ~$past(dig_mask)) == 32'h0))
        else $error("pullup on analog pin");
endmodule

/* pxb_pad_model.sv */
/*
 Pad and board model: resolves each pin level from design drive, board drive and pullup.
 Assumes one system clock; a pin nobody drives without pullup flips each cycle.
*/
`timescale 1ns/100ps
module pxb_pad_model (
    input  wire logic        clock,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] pin_pullup,
    input  wire logic [31:0] ext_en,
    input  wire logic [31:0] ext_val,
    output logic      [31:0] pin_in
);
    logic [31:0] last_reg = 32'h0;
    // ==========================================================
    // Design drive wins, then board, then pullup; an undriven pin without pullup never repeats its old level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pin_pullup | ~last_reg));
    always_ff @(posedge clock) begin
        last_reg <= pin_in;
    end
endmodule

/* pxb_top_tb.sv */
/*
 Self-checking bench of the port crossbar: register bus, routing, drive modes.
 Assumes the pad model resolves pins and inputs change at the falling edge.
*/
`timescale 1ns/100ps
`include "pxb_cfg.svh"
module pxb_top_tb;
    pxb_pkg::pxb_sfr_req_t sfr;
    pxb_pkg::pxb_periph_t  periph;
    pxb_pkg::pxb_memif_t   memif;
    logic        clock, rst_n, sfr_hit, three_wire, can_sel;
    logic [7:0]  sfr_rdata, an_sel, p1_drv, l, d;
    logic [31:0] pin_in, pin_out, pin_oe, pin_pu, ext_en, ext_val, seed;
    logic [32:0] periph_in;
    logic [1:0]  mode0;
    logic [15:0] p23_drv;
    int          bad_count, checks_done, m;
    logic [7:0]  ad[8] = '{`PXB_ADDR_P0, `PXB_ADDR_P1, `PXB_ADDR_P0DRV, `PXB_ADDR_RA, `PXB_ADDR_RB,
                           `PXB_ADDR_RC, `PXB_ADDR_RD, 8'h55};
    logic [7:0]  rv[8] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  mv[8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hdf, 8'h8f, 8'h00};
    logic [7:0]  ea[17] = '{8'he1, 8'he1, 8'he2, 8'he2, 8'he2, 8'he2, 8'he2, 8'he2, 8'he2, 8'he2,
                            8'he3, 8'he3, 8'he3, 8'he4, 8'he4, 8'he4, 8'he4};
    logic [7:0]  ev[17] = '{8'h80, 8'h40, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01,
                            8'h50, 8'h48, 8'h41, 8'h08, 8'h04, 8'h02, 8'h01};
    int          es[17] = '{17, 16, 30, 25, 24, 23, 22, 21, 20, 18, 29, 28, 31, 19, 32, 27, 26};

    pxb_top u_dut (.clock(clock), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu), .periph(periph),
        .periph_in(periph_in), .memif(memif), .uart_mode0(mode0), .spi_three_wire(three_wire),
        .port1_analog_select(an_sel), .port1_drive_select(p1_drv), .port23_drive_select(p23_drv),
        .can_tx_drive_sel(can_sel));
    pxb_pad_model u_pad (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    // ==========================================================
    // Clock and hang guard
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (30000) @(posedge clock);
        bad_count++;
        summarize();
    end
    // ==========================================================
    // Checking, bus and expectation helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        sfr.addr = a;
        sfr.wdata = v;
        sfr.wr = 1'b1;
        @(negedge clock);
        sfr.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        sfr.addr = a;
        sfr.rd = 1'b1;
        @(negedge clock);
        sfr.rd = 1'b0;
        chk("sfr_rdata", {24'h0, exp}, {24'h0, sfr_rdata});
    endtask
    // Register write, then pin stage, then input sampling: four cycles covers all
    task automatic settle();
        repeat (4) @(negedge clock);
    endtask
    // Board drives both levels on one pin; the routed signal must follow it
    task automatic rt(input int sig, input int pin);
        for (int v = 0; v < 2; v++) begin
            ext_val = $urandom();
            ext_val[pin] = v[0];
            settle();
            chk("periph_in", {31'h0, v[0]}, {31'h0, periph_in[sig]});
        end
    endtask
    function automatic logic [7:0] exp_oe(input logic [7:0] lv, input logic [7:0] dv);
        return dv | ~lv;
    endfunction
    function automatic logic [7:0] exp_lvl(input logic [7:0] lv, input logic [7:0] dv, input logic [7:0] e);
        return (exp_oe(lv, dv) & lv & dv) | (~exp_oe(lv, dv) & e);
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        seed = $urandom(32'ha4d2);
        rst_n = 1'b0;
        sfr = '0;
        periph = '0;
        memif = '0;
        memif.strobe = 3'h7;
        an_sel = 8'hff;
        p1_drv = 8'h00;
        p23_drv = 16'h0;
        mode0 = 2'h0;
        three_wire = 1'b0;
        ext_en = '1;
        ext_val = '1;
        bad_count = 0;
        checks_done = 0;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        // Reset values, masks of reserved bits, unmapped place
        foreach (ad[i]) begin
            rd(ad[i], rv[i]);
            chk("sfr_hit", {31'h0, i < 7}, {31'h0, sfr_hit});
        end
        foreach (ad[i]) begin
            wr(ad[i], 8'hff);
            rd(ad[i], mv[i]);
        end
        chk("can_sel", 32'h1, {31'h0, can_sel});
        for (int i = 3; i < 7; i++) wr(ad[i], 8'h00);
        // Router off keeps all pins input even with low latches and port 0 push-pull
        wr(`PXB_ADDR_P0, 8'h00);
        wr(`PXB_ADDR_P1, 8'h00);
        settle();
        chk("pin_oe", 32'h0, pin_oe);
        wr(`PXB_ADDR_RC, 8'h40);
        settle();
        chk("pin_oe", 32'hffff, {16'h0, pin_oe[15:0]});
        // Random latch, drive mode and board levels on the free port 0 pins
        wr(`PXB_ADDR_P1, 8'hff);
        repeat (4) begin
            l = $urandom();
            d = $urandom();
            an_sel = $urandom();
            ext_val = $urandom();
            wr(`PXB_ADDR_P0, l);
            wr(`PXB_ADDR_P0DRV, d);
            settle();
            chk("pin_oe", {24'h0, exp_oe(l, d)}, {24'h0, pin_oe[7:0]});
            chk("pin_out", {24'h0, l & d}, {24'h0, pin_out[7:0]});
            chk("pin_pullup", {24'h0, an_sel}, {24'h0, pin_pu[15:8]});
            rd(`PXB_ADDR_P0, exp_lvl(l, d, ext_val[7:0]));
            rd(`PXB_ADDR_P1, ext_val[15:8] & an_sel);
            sfr.rmw = 1'b1;
            rd(`PXB_ADDR_P0, l);
            sfr.rmw = 1'b0;
        end
        wr(`PXB_ADDR_RC, 8'hc0);
        settle();
        chk("pin_pullup", 32'h0, pin_pu);
        // First UART with peripheral drive, then SMBus open-drain
        wr(`PXB_ADDR_P0DRV, 8'hff);
        wr(`PXB_ADDR_P0, 8'hff);
        wr(`PXB_ADDR_RC, 8'h40);
        wr(`PXB_ADDR_RA, 8'h04);
        periph.drv_en[0] = 1'b1;
        periph.drv[0] = 1'b0;
        settle();
        chk("pin_out0", 32'h0, {30'h0, pin_oe[0], pin_out[0]} ^ 32'h2);
        rt(1, 1);
        mode0 = 2'h1;
        periph.drv_en[1] = 1'b1;
        periph.drv[1] = 1'b1;
        settle();
        chk("rx0_oe", 32'h0, {31'h0, pin_oe[1]});
        mode0 = 2'h0;
        periph.drv_en = '0;
        wr(`PXB_ADDR_RA, 8'h01);
        periph.drv_en[6] = 1'b1;
        periph.drv[6] = 1'b1;
        settle();
        chk("sda_oe", 32'h0, {31'h0, pin_oe[0]});
        periph.drv_en = '0;
        // Mixed allocation with skipped memory and analog pins
        wr(`PXB_ADDR_P0DRV, 8'h00);
        an_sel = 8'he3;
        wr(`PXB_ADDR_RA, 8'h05);
        wr(`PXB_ADDR_RB, 8'h14);
        wr(`PXB_ADDR_RC, 8'h46);
        rt(6, 2);
        rt(8, 4);
        rt(9, 8);
        rt(23, 13);
        memif.nonmux = 1'b1;
        rt(9, 5);
        rt(23, 9);
        memif.busy = 1'b1;
        memif.addr_hi = $urandom();
        p1_drv = 8'hff;
        settle();
        chk("addr_hi", {30'h0, 1'b1, memif.addr_hi[7]}, {30'h0, pin_oe[15], pin_out[15]});
        memif = '0;
        memif.strobe = 3'h7;
        p1_drv = 8'h00;
        wr(`PXB_ADDR_RC, 8'h44);
        rt(23, 7);
        // SPI with and without the select pin
        wr(`PXB_ADDR_RB, 8'h00);
        wr(`PXB_ADDR_RC, 8'h40);
        wr(`PXB_ADDR_RA, 8'h03);
        rt(6, 4);
        three_wire = 1'b1;
        rt(6, 3);
        // Array module count, every field value
        for (int n = 0; n < 8; n++) begin
            wr(`PXB_ADDR_RA, 8'(n << 3));
            ext_val = 32'h0;
            settle();
            m = (n > 6) ? 6 : n;
            chk("cex_in", 32'h3f & ~((32'h1 << m) - 1), {26'h0, periph_in[15:10]});
        end
        // Each single-pin enable alone lands on pin 0
        wr(`PXB_ADDR_RA, 8'h00);
        foreach (ea[i]) begin
            wr(ea[i], ev[i]);
            rt(es[i], 0);
            wr(ea[i], (ea[i] == `PXB_ADDR_RC) ? 8'h40 : 8'h00);
        end
        summarize();
    end
endmodule
